/* src/instr_field_decode_operand_select.sv */
// Instruction field decode, operand address forming and operand select
// What this block does
// - 7-bit field of the instruction is the octal opcode.
// - 3-bit accumulator select picks one of eight level registers.
// - 3-bit mode: direct, literal, indirect, relative, indexed forms.
// - Index select picks register; indexing only modes 1,3,5,6,7.
// - Accumulator and index share eight registers of active level.
// - Operand field is literal in modes 2,3, else address.
// - Page select picks page map byte; six bits prefix offset.
// - Index carry out of page select never reaches index select.
// - 11-bit offset picks word; top page bits pick module.
// - Operand fetch takes left half if W=0, right if W=1.
// - Instruction fetch ignores W, takes whole word.
// - Full-word operations ignore W; word addresses even.
// - W is bit 0 of operand field; half-word addressing.
// - Byte instructions pick upper or lower byte by opcode.
// - Single-bit instructions use accumulator select as bit position.
// - Move instructions select bit group by operand-field mask.
// - Numerical operands are two's complement, msb is sign.
// - Half-word to full-word replicates sign into upper 16.
// - Full algebraic operand keeps both sign bits equal.
// - Half or full operands; full products, dividends, shift pairs.
// - 39 of 128 opcodes reserved for macro coprocessor.
// - Forbidden access inhibits request, flags, changes to level 74.
`timescale 1ns/100ps
`default_nettype none
module instr_field_decode_operand_select
  import ifd_pkg::*;
(
  input wire logic clk, // 100 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic ir_load, // Load instruction word
  input wire logic [WORD_W-1:0] ir_word, // Fetched instruction word
  output instr_fields_t fields, // Decoded fields
  output logic is_macro, // Opcode for macro coprocessor
  output logic literal_mode, // Field used as operand
  output logic indexing_on, // Mode applies indexing
  output logic [SEL_W-1:0] acc_reg, // Accumulator register number
  output logic [SEL_W-1:0] idx_reg, // Index register number
  output logic [SEL_W-1:0] acc_pair_even, // Even register of a pair
  input wire logic pm_wr, // Page map byte write
  input wire logic [PAGE_SEL_W-1:0] pm_sel, // Page map byte number
  input wire logic [BYTE_W-1:0] pm_data, // Page map byte value
  input wire logic [HALF_W-1:0] ix_value, // Index register contents
  input wire logic [LOC_W-1:0] loc_value, // Next-instruction location
  input wire logic ca_index, // Apply index/relative step
  input wire logic ind_load, // Apply indirect word
  input wire logic [HALF_W-1:0] ind_word, // Indirect word value
  input wire logic mem_req, // Memory access request
  input wire acc_kind_t acc_kind, // Fetch, read or write
  input wire logic word_op, // Full-word operation
  input wire logic byte_op, // Byte operation
  input wire logic numeric, // Numerical operand
  output logic mem_go, // Request passed to memory
  output logic [WADDR_W-1:0] mem_addr, // 17-bit word address
  output logic [SEL_W-1:0] mem_module, // Memory module number
  output logic mem_half, // Half select sent with address
  output logic acc_fault, // Access violation pulse
  output logic lvl_chg_req, // Level change request
  output logic [LEVEL_W-1:0] lvl_chg_num, // Target level
  input wire logic lvl_chg_ack, // Level change taken
  input wire logic opnd_capture, // Memory word valid
  input wire logic [WORD_W-1:0] mem_word, // Memory output word
  output logic [WORD_W-1:0] operand, // Selected operand
  output logic [BYTE_W-1:0] byte_val, // Selected byte
  output logic bit_val, // Selected bit
  output logic [HALF_W-1:0] move_field // Masked bit group
);
  typedef enum logic [1:0] {ST_RUN, ST_LVL_CHG} lvl_state_t;

  logic [WORD_W-1:0] ir_ff;
  logic [WORD_W-1:0] ir_cur;
  logic [BYTE_W-1:0] page_map [NUM_PAGES];
  logic [BYTE_W-1:0] pm_byte;
  logic [PAGE_W-1:0] page_bits;
  acc_ctl_t acc_ctl;
  logic [HALF_W-1:0] idx_ca;
  logic [HALF_W-1:0] ind_ca;
  logic allowed;
  logic req_ok;
  logic [WADDR_W-1:0] nxt_addr;
  logic nxt_half;
  opnd_ctl_t opnd_ctl;
  logic [WORD_W-1:0] sel_operand;
  logic [BYTE_W-1:0] sel_byte;
  logic sel_bit;
  logic [HALF_W-1:0] sel_move;
  logic [WADDR_W-1:0] mem_addr_ff;
  logic mem_half_ff;
  logic mem_go_ff;
  logic acc_fault_ff;
  logic [WORD_W-1:0] operand_ff;
  logic [BYTE_W-1:0] byte_ff;
  logic bit_ff;
  logic [HALF_W-1:0] move_ff;
  lvl_state_t lvl_ff;
  lvl_state_t nxt_lvl;

  // =====================================================
  // Access permission by control bits
  function automatic logic permit(input acc_ctl_t c, input acc_kind_t k);
    case (c)
      ACC_RW: permit = 1'b1;
      ACC_RD: permit = (k != ACC_WRITE);
      ACC_RD_DATA: permit = (k == ACC_READ);
      default: permit = 1'b0;
    endcase
  endfunction

  // =====================================================
  // Instruction register
  // Load wins over the indirect and index steps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir_ff <= WORD_RST;
    end else if (ir_load) begin
      ir_ff <= ir_word;
    end else if (ind_load) begin
      ir_ff <= {ir_ff[WORD_W-1:HALF_W], ind_ca};
    end else if (ca_index) begin
      // only the low half is rewritten
      ir_ff <= {ir_ff[WORD_W-1:HALF_W], idx_ca};
    end
  end

  // Bypass lets a word decode as it loads
  // fields valid in load cycle
  assign ir_cur = ir_load ? ir_word : ir_ff;

  // =====================================================
  // Field decode
  // opcode field
  assign fields.opcode = ir_cur[OPC_LSB +: OPC_W];
  assign fields.acc_sel = ir_cur[ACC_LSB +: SEL_W];
  assign fields.mode = addr_mode_t'(ir_cur[MODE_LSB +: SEL_W]);
  assign fields.idx_sel = ir_cur[IDX_LSB +: SEL_W];
  assign fields.operand_field = ir_cur[HALF_W-1:0];

  // both name the active level's set
  assign acc_reg = fields.acc_sel;
  assign idx_reg = fields.idx_sel;
  assign acc_pair_even = {fields.acc_sel[SEL_W-1:1], 1'b0};

  assign is_macro = (fields.opcode >= MACRO_FIRST) &&
                    (fields.opcode <= MACRO_LAST);

  assign literal_mode = (fields.mode == M_LITERAL) ||
                        (fields.mode == M_LITERAL_IX);

  ifd_addr_arith u_arith (
    .mode(fields.mode),
    .idx_sel(fields.idx_sel),
    .ca(fields.operand_field),
    .ix_value(ix_value),
    .loc_value(loc_value),
    .ind_word(ind_word),
    .idx_ca(idx_ca),
    .ind_ca(ind_ca),
    .indexed(indexing_on)
  );

  // =====================================================
  // Page map, loaded on level change
  // One byte per page, written one at a time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_PAGES; i++) begin
        page_map[i] <= PAGE_RST;
      end
    end else if (pm_wr) begin
      page_map[pm_sel] <= pm_data;
    end
  end

  assign pm_byte = page_map[fields.operand_field[PAGE_SEL_LSB +: PAGE_SEL_W]];
  assign page_bits = pm_byte[PAGE_W-1:0];
  assign acc_ctl =
    acc_ctl_t'(pm_byte[ACC_CTL_LSB +: $bits(acc_ctl_t)]);

  assign nxt_addr = {page_bits, fields.operand_field[OFFS_LSB +: OFFS_W]};
  assign nxt_half = (acc_kind == ACC_FETCH || word_op) ? 1'b0 :
                    fields.operand_field[HALF_BIT];

  assign allowed = permit(acc_ctl, acc_kind);

  // refused while a level change is pending
  assign req_ok = mem_req && (lvl_ff == ST_RUN) &&
                  !acc_fault_ff;

  // =====================================================
  // Memory request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_go_ff <= 1'b0;
      acc_fault_ff <= 1'b0;
    end else begin
      mem_go_ff <= req_ok && allowed;
      acc_fault_ff <= req_ok && !allowed;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_addr_ff <= '0;
      mem_half_ff <= 1'b0;
    end else if (req_ok && allowed) begin
      // Refused requests keep the last address
      mem_addr_ff <= nxt_addr;
      mem_half_ff <= nxt_half;
    end
  end

  assign mem_go = mem_go_ff;
  assign acc_fault = acc_fault_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_half = mem_half_ff;
  assign mem_module = mem_addr_ff[WADDR_W-1 -: SEL_W];

  // =====================================================
  // Level change to error level
  always_comb begin
    nxt_lvl = lvl_ff;
    case (lvl_ff)
      ST_RUN: begin
        if (acc_fault_ff) begin
          nxt_lvl = ST_LVL_CHG;
        end
      end
      ST_LVL_CHG: begin
        if (lvl_chg_ack) begin
          nxt_lvl = ST_RUN;
        end
      end
      default: nxt_lvl = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_ff <= ST_RUN;
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  // Level held until the processor acknowledges
  assign lvl_chg_req = (lvl_ff == ST_LVL_CHG);
  assign lvl_chg_num = ERR_LEVEL;

  // =====================================================
  // Operand selection
  // Kind flags must stand until the word is captured
  assign opnd_ctl.word_op = word_op;
  assign opnd_ctl.byte_op = byte_op;
  assign opnd_ctl.numeric = numeric;
  assign opnd_ctl.literal = literal_mode;

  ifd_operand_sel u_opnd (
    .ctl(opnd_ctl),
    .mem_word(mem_word),
    .ca(fields.operand_field),
    .opcode(fields.opcode),
    .acc_sel(fields.acc_sel),
    .operand(sel_operand),
    .byte_val(sel_byte),
    .bit_val(sel_bit),
    .move_field(sel_move)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operand_ff <= WORD_RST;
      byte_ff <= '0;
      bit_ff <= 1'b0;
      move_ff <= '0;
    end else if (opnd_capture) begin
      operand_ff <= sel_operand;
      byte_ff <= byte_op ? sel_byte : '0;
      bit_ff <= sel_bit;
      move_ff <= sel_move;
    end
  end

  assign operand = operand_ff;
  assign byte_val = byte_ff;
  assign bit_val = bit_ff;
  assign move_field = move_ff;
endmodule // instr_field_decode_operand_select
`default_nettype wire

/* inc/ifd_pkg.sv */
// Shared constants and types for the instruction field decoder
package ifd_pkg;
  // =====================================================
  // Instruction word layout
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int OPC_W = 7;
  localparam int SEL_W = 3;
  localparam int PAGE_SEL_W = 4;
  localparam int OFFS_W = 11;
  localparam int PAGE_W = 6;
  localparam int WADDR_W = 17;
  localparam int LOC_W = 15;
  localparam int LEVEL_W = 6;
  localparam int NUM_PAGES = 16;
  localparam int OPC_LSB = 25;
  localparam int ACC_LSB = 22;
  localparam int MODE_LSB = 19;
  localparam int IDX_LSB = 16;
  localparam int OFFS_LSB = 1;
  localparam int HALF_BIT = 0;
  localparam int PAGE_SEL_LSB = 12;
  localparam int ACC_CTL_LSB = 6;
  localparam int MODULE_LSB = 3;
  localparam int BYTE_SEL_BIT = 0;
  // =====================================================
  // Opcode space and levels
  localparam logic [6:0] MACRO_FIRST = 7'h59;
  localparam logic [6:0] MACRO_LAST = 7'h7F;
  localparam logic [5:0] ERR_LEVEL = 6'h3C;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // =====================================================
  // Types
  typedef enum logic [2:0] {
    M_DIRECT, M_DIRECT_IX, M_LITERAL, M_LITERAL_IX,
    M_INDIRECT, M_IX_INDIRECT, M_INDIRECT_IX, M_RELATIVE
  } addr_mode_t;
  typedef enum logic [1:0] {
    ACC_FETCH, ACC_READ, ACC_WRITE
  } acc_kind_t;
  typedef enum logic [1:0] {
    ACC_RW, ACC_RD, ACC_RD_DATA, ACC_NONE
  } acc_ctl_t;
  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic [SEL_W-1:0] acc_sel;
    addr_mode_t mode;
    logic [SEL_W-1:0] idx_sel;
    logic [HALF_W-1:0] operand_field;
  } instr_fields_t;
  typedef struct packed {
    logic word_op;
    logic byte_op;
    logic numeric;
    logic literal;
  } opnd_ctl_t;
endpackage

/* src/ifd_addr_arith.sv */
// Operand-field address arithmetic for indexing and relative modes
`timescale 1ns/100ps
`default_nettype none
module ifd_addr_arith
  import ifd_pkg::*;
(
  input wire addr_mode_t mode, // Address mode
  input wire logic [SEL_W-1:0] idx_sel, // Index select
  input wire logic [HALF_W-1:0] ca, // Current operand field
  input wire logic [HALF_W-1:0] ix_value, // Index register contents
  input wire logic [LOC_W-1:0] loc_value, // Next-instruction location
  input wire logic [HALF_W-1:0] ind_word, // Indirect word from memory
  output logic [HALF_W-1:0] idx_ca, // Field after index step
  output logic [HALF_W-1:0] ind_ca, // Field after indirect step
  output logic indexed // Mode applies indexing
);
  logic [LOC_W-1:0] rel_da;
  logic [HALF_W-1:0] rel_base;

  // =====================================================
  // Index and relative sums, 16 bits only
  // carry dropped
  assign rel_da = ca[HALF_W-1:OFFS_LSB] + loc_value;
  assign rel_base = ca + {1'b0, loc_value};

  always_comb begin
    indexed = 1'b0;
    idx_ca = ca;
    case (mode)
      M_DIRECT_IX, M_LITERAL_IX, M_IX_INDIRECT: begin
        indexed = 1'b1;
        idx_ca = ca + ix_value;
      end
      M_INDIRECT_IX: indexed = 1'b1;
      M_RELATIVE: begin
        indexed = (idx_sel != '0);
        if (idx_sel == '0) begin
          idx_ca = {rel_da, ca[HALF_BIT]};
        end else begin
          idx_ca = rel_base + ix_value;
        end
      end
      default: idx_ca = ca;
    endcase
  end

  // Indirect word, indexed afterwards in mode 6
  assign ind_ca = (mode == M_INDIRECT_IX) ? ind_word + ix_value : ind_word;
endmodule // ifd_addr_arith
`default_nettype wire

/* src/ifd_operand_sel.sv */
// Operand selection from a memory word or literal field
`timescale 1ns/100ps
`default_nettype none
module ifd_operand_sel
  import ifd_pkg::*;
(
  input wire opnd_ctl_t ctl, // Operand kind
  input wire logic [WORD_W-1:0] mem_word, // Memory output word
  input wire logic [HALF_W-1:0] ca, // Operand field
  input wire logic [OPC_W-1:0] opcode, // Operation code
  input wire logic [SEL_W-1:0] acc_sel, // Bit select in byte ops
  output logic [WORD_W-1:0] operand, // Selected operand
  output logic [BYTE_W-1:0] byte_val, // Selected byte
  output logic bit_val, // Selected bit
  output logic [HALF_W-1:0] move_field // Masked bit group
);
  logic [HALF_W-1:0] half;
  logic [WORD_W-1:0] full;

  // =====================================================
  // Half and full selection
  // half by W
  assign half = ctl.literal ? ca :
                ca[HALF_BIT] ? mem_word[HALF_W-1:0] :
                mem_word[WORD_W-1:HALF_W];
  assign full = mem_word;

  always_comb begin
    if (ctl.word_op) begin
      operand = full;
      if (ctl.numeric) begin
        operand[HALF_W-1] = full[WORD_W-1];
      end
    end else if (ctl.numeric) begin
      operand = {{HALF_W{half[HALF_W-1]}}, half};
    end else begin
      operand = {{HALF_W{1'b0}}, half};
    end
  end

  assign byte_val = opcode[BYTE_SEL_BIT] ? half[BYTE_W-1:0] :
                    half[HALF_W-1:BYTE_W];
  // bit by acc_sel, 0 is msb
  assign bit_val = byte_val[(BYTE_W-1) - acc_sel];
  assign move_field = half & ca;
endmodule // ifd_operand_sel
`default_nettype wire

/* bench/ifd_monitor.sv */
// Port checker for the instruction field decoder
`timescale 1ns/100ps
`default_nettype none
module ifd_monitor
  import ifd_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic ir_load, // Load strobe
  input wire logic [WORD_W-1:0] ir_word, // Word in
  input wire instr_fields_t fields, // Decoded fields
  input wire logic is_macro, // Macro opcode
  input wire logic literal_mode, // Literal mode
  input wire logic indexing_on, // Indexing mode
  input wire logic [SEL_W-1:0] acc_reg, // Accumulator
  input wire logic [SEL_W-1:0] idx_reg, // Index register
  input wire logic mem_req, // Request
  input wire acc_kind_t acc_kind, // Access kind
  input wire logic word_op, // Full word
  input wire logic mem_go, // Granted
  input wire logic [WADDR_W-1:0] mem_addr, // Word address
  input wire logic [SEL_W-1:0] mem_module, // Module
  input wire logic mem_half, // Half select
  input wire logic acc_fault, // Fault pulse
  input wire logic lvl_chg_req, // Level change
  input wire logic [LEVEL_W-1:0] lvl_chg_num // Target level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Decode
  AST_LOAD: assert property (ir_load |-> fields == ir_word)
    else $error("fields differ from loaded word");
  AST_MACRO: assert property (is_macro == (fields.opcode >= 7'h59))
    else $error("macro flag wrong");
  AST_LIT: assert property (
    literal_mode == (fields.mode inside {M_LITERAL, M_LITERAL_IX}))
    else $error("literal flag wrong");
  AST_IDX: assert property (indexing_on == (
    fields.mode inside {M_DIRECT_IX, M_LITERAL_IX, M_IX_INDIRECT,
    M_INDIRECT_IX} || (fields.mode == M_RELATIVE && fields.idx_sel != 0)))
    else $error("indexing flag wrong");
  AST_REG: assert property (
    acc_reg == fields.acc_sel && idx_reg == fields.idx_sel)
    else $error("register select wrong");
  // ==========================================
  // Memory requests
  AST_GO: assert property (
    mem_req && !lvl_chg_req && !acc_fault |=> mem_go ^ acc_fault)
    else $error("request not answered once");
  AST_MOD: assert property (mem_go |-> mem_module == mem_addr[16:14])
    else $error("module number wrong");
  AST_HALF: assert property (
    mem_go && $past(acc_kind == ACC_FETCH || word_op) |-> !mem_half)
    else $error("half select not cleared");
  AST_LVL: assert property (
    acc_fault |=> lvl_chg_req && lvl_chg_num == 6'h3C)
    else $error("level change missing");
  AST_NOGO: assert property (lvl_chg_req |=> !(mem_go || acc_fault))
    else $error("request served during level change");
  C_GO: cover property (mem_go);
  C_FAULT: cover property (acc_fault);
  C_END: cover property ($fell(lvl_chg_req));
endmodule // ifd_monitor
`default_nettype wire

/* bench/ifd_mem_model.sv */
// Memory model answering granted requests with a word
`timescale 1ns/100ps
`default_nettype none
module ifd_mem_model
  import ifd_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic mem_go, // Granted request
  input wire logic [WADDR_W-1:0] mem_addr, // Word address
  output logic opnd_capture, // Word valid
  output logic [WORD_W-1:0] mem_word // Memory word
);
  logic [WORD_W-1:0] mem [32];
  // ==========================================
  // Answer one cycle after grant
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opnd_capture <= 1'b0;
      mem_word <= 32'h0000_0000;
    end else begin
      opnd_capture <= mem_go;
      // Idle data toggles so stale words never look valid
      mem_word <= mem_go ? mem[mem_addr[4:0]] : ~mem_word;
    end
  end
endmodule // ifd_mem_model
`default_nettype wire

/* bench/instr_field_decode_operand_select_tb.sv */
// Testbench for the instruction field decoder
`timescale 1ns/100ps
`default_nettype none
module instr_field_decode_operand_select_tb;
  import ifd_pkg::*;
  logic clk, nrst, ir_load, pm_wr, ca_index, ind_load, mem_req;
  logic word_op, byte_op, numeric, lvl_chg_ack, opnd_capture, is_macro;
  logic literal_mode, indexing_on, mem_go, mem_half, acc_fault;
  logic lvl_chg_req, bit_val;
  logic cap_d = 1'b0;
  logic [31:0] ir_word, mem_word, operand, w;
  logic [2:0] acc_reg, idx_reg, acc_pair_even, mem_module, f;
  logic [3:0] pm_sel;
  logic [7:0] pm_data, byte_val;
  logic [7:0] pm [16];
  logic [15:0] ix_value, ind_word, move_field;
  logic [14:0] loc_value;
  logic [16:0] mem_addr;
  logic [5:0] lvl_chg_num;
  logic [18:0] e;
  logic [58:0] o;
  instr_fields_t fields;
  acc_kind_t acc_kind, k;
  logic [18:0] exp_q [$];
  logic [58:0] opq [$];
  int checks, n_fail, cyc;
  instr_field_decode_operand_select dut_u (.*);
  ifd_mem_model p_u (.clk(clk), .nrst(nrst), .mem_go(mem_go),
    .mem_addr(mem_addr), .opnd_capture(opnd_capture), .mem_word(mem_word));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic load(input logic [31:0] v);
    @(posedge clk);
    ir_word <= v;
    ir_load <= 1'b1;
    @(posedge clk);
    ir_load <= 1'b0;
  endtask
  // ==========================================
  // One memory access with its expectations
  task automatic access();
    logic [15:0] ca, h;
    logic [31:0] md, op;
    logic [7:0] pb, by;
    logic ok;
    load(w);
    ca = w[15:0];
    pb = pm[ca[15:12]];
    ok = (k == ACC_READ) ? pb[7:6] != 2'b11 :
      (k == ACC_FETCH) ? pb[7:6] < 2'b10 : pb[7:6] == 2'b00;
    md = p_u.mem[ca[5:1]];
    h = (w[21:20] == 2'b01) ? ca : ca[0] ? md[15:0] : md[31:16];
    op = f[0] ? {{16{h[15]}}, h} : {16'h0000, h};
    if (f[2]) op = f[0] ? {md[31:16], md[31], md[14:0]} : md;
    by = f[1] ? (w[25] ? h[7:0] : h[15:8]) : 8'h00;
    acc_kind <= k;
    word_op <= f[2];
    byte_op <= f[1];
    numeric <= f[0];
    mem_req <= 1'b1;
    exp_q.push_back({ok, ok ? {pb[5:0], ca[11:1],
      ca[0] & (k != ACC_FETCH) & !f[2]} : 18'h00000});
    if (ok) opq.push_back({f[2], f[1], op, by, by[7 - w[24:22]], h & ca});
    @(posedge clk);
    mem_req <= 1'b0;
    if (ok) repeat (4) @(posedge clk);
    else begin
      for (int n = 0; n < 10 && lvl_chg_req !== 1'b1; n++) @(negedge clk);
      check(lvl_chg_num, 6'h3C);
      @(posedge clk);
      mem_req <= 1'b1;
      @(posedge clk);
      mem_req <= 1'b0;
      lvl_chg_ack <= 1'b1;
      @(posedge clk);
      lvl_chg_ack <= 1'b0;
      repeat (2) @(negedge clk);
      check(lvl_chg_req, 1'b0);
    end
  endtask
  // ==========================================
  // Result watcher
  always @(posedge clk) begin
    #1;
    if (cap_d && opq.size() > 0) begin
      o = opq.pop_front();
      check(operand, o[56:25]);
      if (!o[58]) check({byte_val, move_field}, {o[24:17], o[15:0]});
      if (o[57]) check(bit_val, o[16]);
    end
    cap_d = opnd_capture;
    if (mem_go || acc_fault) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else begin
        e = exp_q.pop_front();
        check({mem_go, mem_go ? {mem_addr, mem_half} : 18'h0}, e);
      end
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    {nrst, ir_load, pm_wr, ca_index, ind_load, mem_req} = '0;
    {word_op, byte_op, numeric, lvl_chg_ack} = '0;
    {ir_word, ix_value, ind_word, loc_value, pm_sel, pm_data} = '0;
    acc_kind = ACC_FETCH;
    void'($urandom(32'hA6AB1F4F));
    for (int i = 0; i < 32; i++) p_u.mem[i] = $urandom;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check({fields, operand}, 64'h0);
    for (int i = 0; i < 128; i++) begin
      w = $urandom;
      w[31:25] = i[6:0];
      w[21:19] = i[2:0];
      load(w);
      @(negedge clk);
      check(fields, w);
      check(is_macro, i >= 89);
      check(literal_mode, i[2:1] == 2'b01);
      check(indexing_on, i[2:0] inside {1, 3, 5, 6} ||
        (i[2:0] == 7 && w[18:16] != 0));
      check({acc_reg, idx_reg}, {w[24:22], w[18:16]});
      check(acc_pair_even, {w[24:23], 1'b0});
    end
    w = {7'h01, 3'h2, 3'h1, 3'h5, 16'hF000};
    load(w);
    ix_value <= 16'h2000;
    ca_index <= 1'b1;
    @(posedge clk);
    ca_index <= 1'b0;
    @(negedge clk);
    check(fields, {w[31:16], 16'h1000});
    // Relative, no index: top 15 bits plus location, carry lost
    w = {7'h02, 3'h1, 3'h7, 3'h0, 16'h8003};
    load(w);
    loc_value <= 15'h4001;
    ca_index <= 1'b1;
    @(posedge clk);
    ca_index <= 1'b0;
    @(negedge clk);
    check(fields, {w[31:16], 16'h0005});
    // Indirect then indexed: word plus index, carry lost
    w = {7'h03, 3'h0, 3'h6, 3'h4, 16'h1234};
    load(w);
    ix_value <= 16'h0101;
    ind_word <= 16'hFF00;
    ind_load <= 1'b1;
    @(posedge clk);
    ind_load <= 1'b0;
    @(negedge clk);
    check(fields, {w[31:16], 16'h0001});
    for (int i = 0; i < 16; i++) begin
      pm[i] = 8'($urandom);
      pm[i][7:6] = i[1:0];
      @(posedge clk);
      pm_wr <= 1'b1;
      pm_sel <= i[3:0];
      pm_data <= pm[i];
    end
    @(posedge clk);
    pm_wr <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      w = $urandom;
      k = acc_kind_t'($urandom_range(2));
      f = 3'($urandom);
      if (f[2]) f[1] = 1'b0;
      // Literal operands are half-words only
      if (w[21:20] == 2'b01) f[2] = 1'b0;
      access();
    end
    repeat (4) @(posedge clk);
    check(exp_q.size() + opq.size(), 0);
    print_verdict();
  end
endmodule // instr_field_decode_operand_select_tb
bind instr_field_decode_operand_select ifd_monitor mon_u (.clk(clk),
  .nrst(nrst), .ir_load(ir_load), .ir_word(ir_word), .fields(fields),
  .is_macro(is_macro), .literal_mode(literal_mode),
  .indexing_on(indexing_on), .acc_reg(acc_reg), .idx_reg(idx_reg),
  .mem_req(mem_req), .acc_kind(acc_kind), .word_op(word_op),
  .mem_go(mem_go), .mem_addr(mem_addr), .mem_module(mem_module),
  .mem_half(mem_half), .acc_fault(acc_fault), .lvl_chg_req(lvl_chg_req),
  .lvl_chg_num(lvl_chg_num));
`default_nettype wire
